// ==== shared/mrab_pkg.sv ====
// Summary of operation
// R01: metering registers reachable only through buffer bytes
// R02: any level-one reset clears all buffer registers
// R03: six byte buffers at indices 0x2880..0x2885
// R04: read needs unlock write 0xcc then zero
// R05: read access to target address starts read
// R06: read loads data word, ack clears within 24
// R07: software reads data bytes after ack clears
// R08: write needs unlock write 0xcc then zero
// R09: software loads data bytes before the address
// R10: write access to target address starts write
// R11: write copies data word, ack clears within 24
// R12: ack held during transfer; unlocked accesses only
// R13: metering tick base 819.2kHz, times one/two/four
package mrab_pkg;

    // ----------
    // clock and metering timing
    // ----------
    localparam int unsigned CLK_HZ          = 250_000_000;  // clk_sys rate
    localparam int unsigned METERING_CLOCK_BASE_HZ   = 819_200;      // metering clock base
    localparam int unsigned METERING_CLOCK_BASE_DIV  = CLK_HZ / METERING_CLOCK_BASE_HZ; // cycles per base period
    localparam int unsigned ACK_MAX_PERIODS = 24;           // longest transfer in periods
    localparam logic [1:0]  METERING_CLOCK_SEL_RST   = 2'h0;         // base rate after reset

    // ----------
    // register indices; byte address is four times the index
    // ----------
    localparam logic [15:0] IDX_DATA_LOW      = 16'h2880;
    localparam logic [15:0] IDX_DATA_MID_LOW  = 16'h2881;
    localparam logic [15:0] IDX_DATA_MID_HIGH = 16'h2882;
    localparam logic [15:0] IDX_DATA_HIGH     = 16'h2883;
    localparam logic [15:0] IDX_UNLOCK        = 16'h2884;
    localparam logic [15:0] IDX_DONE          = 16'h2885;
    localparam logic [15:0] IDX_CLK_SEL       = 16'h2888;   // metering rate select
    localparam logic [7:0]  IDX_METER_WIN     = 8'h10;      // upper index byte of window

    // ----------
    // field values and reset values
    // ----------
    localparam logic [7:0]  UNLOCK_KEY      = 8'hcc;
    localparam logic [7:0]  UNLOCK_CLOSE    = 8'h00;
    localparam logic [7:0]  BYTE_RST        = 8'h00;
    localparam logic [7:0]  DONE_IDLE       = 8'h00;
    localparam logic [7:0]  DONE_BUSY       = 8'h01;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // unlock progress
    typedef enum logic [1:0] {
        UNL_LOCKED = 2'b00,
        UNL_ARMED  = 2'b01,
        UNL_OPEN   = 2'b10
    } mrab_unlock_t;

    // transfer sequencer
    typedef enum logic [1:0] {
        XF_IDLE  = 2'b00,
        XF_ISSUE = 2'b01,
        XF_WAIT  = 2'b10
    } mrab_xfer_t;

endpackage

// ==== core/mrab_tick_gen.sv ====
`timescale 1ns/1ps
module mrab_tick_gen #(
    parameter int unsigned BASE_DIV = mrab_pkg::METERING_CLOCK_BASE_DIV
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [1:0] rateSel,  // 0 x1, 1 x2, else x4
    output logic            tick      // one cycle per metering period
);
    import mrab_pkg::*;

    // ----------
    // divider
    // ----------
    localparam logic [15:0] DIV1 = 16'(BASE_DIV);
    logic [15:0] count_q;     // cycles into current period
    logic [15:0] periodLast;  // terminal count for chosen rate
    logic        tick_q;

    // faster rates shorten the period; fractions of a cycle are dropped
    assign periodLast = (rateSel == 2'h0) ? DIV1 - 16'h0001 :
                        (rateSel == 2'h1) ? (DIV1 >> 1) - 16'h0001 :
                                            (DIV1 >> 2) - 16'h0001;
    assign tick = tick_q;

    // counter wraps at the period end and pulses tick
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            count_q <= 16'h0000;
            tick_q  <= 1'b0;
        end
        else
        begin
            tick_q  <= (count_q >= periodLast);                    // R13
            count_q <= (count_q >= periodLast) ? 16'h0000 : count_q + 16'h0001;
        end
    end
endmodule

// ==== core/mrab_bridge.sv ====
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module mrab_bridge #(
    parameter int unsigned ADDR_W  = 18,   // axi byte address width
    parameter int unsigned MADDR_W = 8     // metering register address width
) (
    input  wire logic                clk_sys,
    input  wire logic                reset,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // metering engine side, same clock
    output logic                     metReq,
    output logic                     metWrite,
    output logic [MADDR_W-1:0]       metAddr,
    output logic [31:0]              metWrData,
    input  wire logic [31:0]         metRdData,
    input  wire logic                metAck
);
    import mrab_pkg::*;

    // ----------
    // axi channel state
    // ----------
    logic              awReady_q, wReady_q, arReady_q;   // channel readies
    logic              awHeld_q, wHeld_q;                // captured halves of a write
    logic [ADDR_W-1:0] awAddr_q, arAddr_q;               // captured addresses
    logic [31:0]       wData_q;                          // captured write data
    logic [3:0]        wStrb_q;                          // captured strobes
    logic              bValid_q, rValid_q, rdPend_q;     // answer state
    logic [1:0]        bResp_q, rResp_q;
    logic [31:0]       rData_q;

    // ----------
    // buffer and control state
    // ----------
    logic [7:0]        dataByte_q [4];       // data word, byte 0 lowest
    logic [7:0]        unlock_q;             // last unlock byte written
    mrab_unlock_t      unl_q, unl_d;         // unlock progress
    mrab_xfer_t        xf_q;                 // transfer sequencer
    logic [1:0]        clkSel_q;             // metering rate select
    logic [4:0]        tickCnt_q;            // periods spent waiting
    logic              metReq_q, metWrite_q;
    logic [MADDR_W-1:0] metAddr_q;
    logic [31:0]       metWrData_q;
    logic              mtTick;

    // ----------
    // decode
    // ----------
    wire [15:0] wrIdx   = 16'(awAddr_q >> 2);
    wire [15:0] rdIdx   = 16'(arAddr_q >> 2);
    wire        wrGo    = awHeld_q && wHeld_q && !bValid_q;   // both halves present
    wire        wrStrb0 = wStrb_q[0];                         // byte registers use lane 0
    wire        wrWin   = wrIdx[15:8] == IDX_METER_WIN;
    wire        rdWin   = rdIdx[15:8] == IDX_METER_WIN;
    wire        wrData  = wrIdx[15:2] == IDX_DATA_LOW[15:2];  // four data bytes
    wire        wrUnl   = wrIdx == IDX_UNLOCK;
    wire        wrDone  = wrIdx == IDX_DONE;
    wire        wrCsel  = wrIdx == IDX_CLK_SEL;
    wire        wrHit   = wrWin || wrData || wrUnl || wrDone || wrCsel;
    wire        rdData  = rdIdx[15:2] == IDX_DATA_LOW[15:2];
    wire        rdUnl   = rdIdx == IDX_UNLOCK;
    wire        rdDone  = rdIdx == IDX_DONE;
    wire        rdCsel  = rdIdx == IDX_CLK_SEL;
    wire        rdHit   = rdWin || rdData || rdUnl || rdDone || rdCsel;
    wire        idle    = xf_q == XF_IDLE;
    // address accesses start only when unlocked and idle; a write wins a tie
    wire        startWr = wrGo && wrWin && idle && unl_q == UNL_OPEN;            // R10 R12
    wire        startRd = rdPend_q && rdWin && idle && unl_q == UNL_OPEN && !startWr; // R05 R12
    wire        tmo     = mtTick && tickCnt_q == 5'(ACK_MAX_PERIODS - 1);
    wire [7:0]  doneVal = idle ? DONE_IDLE : DONE_BUSY;                          // R12
    wire [31:0] dataWord = {dataByte_q[3], dataByte_q[2], dataByte_q[1], dataByte_q[0]};
    wire [7:0]  rdByte  = rdData ? dataByte_q[rdIdx[1:0]] :
                          rdUnl  ? unlock_q :
                          rdDone ? doneVal :
                          rdCsel ? {6'h00, clkSel_q} : 8'h00;

    // unlock progress: key then zero opens; anything else relocks
    always_comb
    begin
        unl_d = unl_q;
        if (startWr || startRd)
            unl_d = UNL_LOCKED;                              // one access per unlock
        else if (wrGo && wrUnl && wrStrb0)
        begin
            if (wData_q[7:0] == UNLOCK_KEY)
                unl_d = UNL_ARMED;                           // R04 R08
            else if (wData_q[7:0] == UNLOCK_CLOSE && unl_q == UNL_ARMED)
                unl_d = UNL_OPEN;                            // R04 R08
            else
                unl_d = UNL_LOCKED;
        end
    end

    // ----------
    // metering period source
    // ----------
    mrab_tick_gen u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .rateSel (clkSel_q),
        .tick    (mtTick)
    );

    // ----------
    // axi write channels
    // ----------
    // readies drop on capture and return once the response is taken
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            awReady_q <= 1'b1;
            wReady_q  <= 1'b1;
            awHeld_q  <= 1'b0;
            wHeld_q   <= 1'b0;
            awAddr_q  <= '0;
            wData_q   <= 32'h0000_0000;
            wStrb_q   <= 4'h0;
            bValid_q  <= 1'b0;
            bResp_q   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && awReady_q)
            begin
                awAddr_q  <= s_axi_awaddr;
                awHeld_q  <= 1'b1;
                awReady_q <= 1'b0;
            end
            if (s_axi_wvalid && wReady_q)
            begin
                wData_q  <= s_axi_wdata;
                wStrb_q  <= s_axi_wstrb;
                wHeld_q  <= 1'b1;
                wReady_q <= 1'b0;
            end
            if (wrGo)
            begin
                bValid_q <= 1'b1;
                bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;  // unmapped answer
            end
            if (bValid_q && s_axi_bready)
            begin
                bValid_q  <= 1'b0;
                awHeld_q  <= 1'b0;
                wHeld_q   <= 1'b0;
                awReady_q <= 1'b1;
                wReady_q  <= 1'b1;
            end
        end
    end

    // ----------
    // axi read channels
    // ----------
    // one cycle to decode, then data held until taken
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            arReady_q <= 1'b1;
            arAddr_q  <= '0;
            rdPend_q  <= 1'b0;
            rValid_q  <= 1'b0;
            rData_q   <= 32'h0000_0000;
            rResp_q   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && arReady_q)
            begin
                arAddr_q  <= s_axi_araddr;
                arReady_q <= 1'b0;
                rdPend_q  <= 1'b1;
            end
            if (rdPend_q)
            begin
                rdPend_q <= 1'b0;
                rValid_q <= 1'b1;
                rData_q  <= {24'h00_0000, rdByte};  // window reads return zero
                rResp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (rValid_q && s_axi_rready)
            begin
                rValid_q  <= 1'b0;
                arReady_q <= 1'b1;
            end
        end
    end

    // ----------
    // buffer bytes, one per lane of the data word
    // ----------
    for (genvar b = 0; b < 4; b++)
    begin : g_byte
        wire swWr = wrGo && wrData && wrStrb0 && wrIdx[1:0] == 2'(b);   // R09
        wire hwWr = xf_q == XF_WAIT && metAck && !metWrite_q;          // R06
        // engine data replaces software data when a read completes
        always_ff @(posedge clk_sys or posedge reset)
        begin
            if (reset)
                dataByte_q[b] <= BYTE_RST;                             // R02
            else if (hwWr)
                dataByte_q[b] <= metRdData[8*b +: 8];                  // R03 R06
            else if (swWr)
                dataByte_q[b] <= wData_q[7:0];                         // R03
        end
    end

    // ----------
    // unlock byte and rate select
    // ----------
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            unlock_q <= BYTE_RST;                          // R02
            unl_q    <= UNL_LOCKED;                        // R02
            clkSel_q <= METERING_CLOCK_SEL_RST;
        end
        else
        begin
            unl_q <= unl_d;
            if (wrGo && wrUnl && wrStrb0)
                unlock_q <= wData_q[7:0];                  // R03
            if (wrGo && wrCsel && wrStrb0)
                clkSel_q <= wData_q[1:0];                  // R13
        end
    end

    // ----------
    // transfer sequencer
    // ----------
    // the only path to metering registers; requests align to a period
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            xf_q        <= XF_IDLE;                        // R02
            tickCnt_q   <= 5'h00;
            metReq_q    <= 1'b0;
            metWrite_q  <= 1'b0;
            metAddr_q   <= '0;
            metWrData_q <= 32'h0000_0000;
        end
        else
        begin
            if (mtTick && !idle)
                tickCnt_q <= tickCnt_q + 5'h01;
            unique case (xf_q)
                XF_IDLE:
                begin
                    tickCnt_q <= 5'h00;
                    if (startWr)
                    begin
                        xf_q        <= XF_ISSUE;            // R01 R12
                        metWrite_q  <= 1'b1;
                        metAddr_q   <= MADDR_W'(wrIdx);
                        metWrData_q <= dataWord;            // R11
                    end
                    else if (startRd)
                    begin
                        xf_q       <= XF_ISSUE;             // R01 R12
                        metWrite_q <= 1'b0;
                        metAddr_q  <= MADDR_W'(rdIdx);
                    end
                end
                XF_ISSUE:
                begin
                    // wait for a period edge before driving the engine
                    if (tmo)
                        xf_q <= XF_IDLE;
                    else if (mtTick)
                    begin
                        metReq_q <= 1'b1;
                        xf_q     <= XF_WAIT;
                    end
                end
                XF_WAIT:
                begin
                    // a silent engine is abandoned at the period bound
                    if (metAck || tmo)
                    begin
                        metReq_q <= 1'b0;
                        xf_q     <= XF_IDLE;                // R06 R11
                    end
                end
                default:
                    xf_q <= XF_IDLE;
            endcase
        end
    end

    // ----------
    // outputs
    // ----------
    assign s_axi_awready = awReady_q;
    assign s_axi_wready  = wReady_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign metReq        = metReq_q;
    assign metWrite      = metWrite_q;
    assign metAddr       = metAddr_q;
    assign metWrData     = metWrData_q;
endmodule

// ==== sim/mrab_properties.sv ====
`timescale 1ns/1ps
// ----------
// port checker for the access bridge
// ----------
module mrab_properties
    import mrab_pkg::*;
#(
    parameter int unsigned ADDR_W  = 18,
    parameter int unsigned MADDR_W = 8
) (
    input wire logic               clk_sys,
    input wire logic               reset,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic [ADDR_W-1:0]  s_axi_araddr,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [1:0]         s_axi_rresp,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic               metReq,
    input wire logic               metWrite,
    input wire logic [MADDR_W-1:0] metAddr,
    input wire logic [31:0]        metWrData,
    input wire logic               metAck
);
    // slowest rate, full 24 periods, a little slack for the tick phase
    localparam int unsigned REQ_MAX = ACK_MAX_PERIODS * METERING_CLOCK_BASE_DIV + 4;
    logic [15:0]      reqLen_q;                          // cycles request has stood
    wire logic [15:0] arIdx = 16'(s_axi_araddr >> 2);    // word index of read
    wire logic        arMapped = (arIdx >= IDX_DATA_LOW && arIdx <= IDX_DONE)
                                 || arIdx == IDX_CLK_SEL || arIdx[15:8] == IDX_METER_WIN;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // length counter; a counter because the bound is far past any delay range
    always_ff @(posedge clk_sys or posedge reset)
        if (reset)
            reqLen_q <= 16'h0;
        else
            reqLen_q <= metReq ? reqLen_q + 16'h1 : 16'h0;
    sequence sWrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence sRdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer_due: assert property (sWrTaken |=> !s_axi_awready ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer_due: assert property (sRdTaken |=> !s_axi_arready ##[0:2] s_axi_rvalid)
        else $error("read response late");
    a_rd_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && !arMapped |=>
        ##[0:2] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    a_req_held_steady: assert property (metReq && !metAck |=> !metReq || ($stable(metAddr)
        && $stable(metWrite) && $stable(metWrData))) else $error("request changed in flight");
    a_req_ack_release: assert property (metReq && metAck |=> !metReq)
        else $error("request kept after ack");
    a_req_time_bound: assert property (reqLen_q <= 16'(REQ_MAX))
        else $error("transfer exceeded bound");
endmodule

bind mrab_bridge mrab_properties #(.ADDR_W(ADDR_W), .MADDR_W(MADDR_W)) chk_u (.*);

// ==== sim/mrab_engine_model.sv ====
`timescale 1ns/1ps
// ----------
// metering engine register file model
// ----------
module mrab_engine_model (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        metReq,
    input wire logic        metWrite,
    input wire logic [7:0]  metAddr,
    input wire logic [31:0] metWrData,
    input wire logic [7:0]  ackDelay,   // cycles before ack, ff never answers
    output logic [31:0]     metRdData,
    output logic            metAck
);
    logic [31:0] regs [256];           // engine registers, only the bridge reaches them
    logic [7:0]  waitCnt;              // cycles into the current request
    logic        served;               // one ack per request
    // answer after the chosen delay; read data toggles outside the ack cycle
    always_ff @(posedge clk_sys or posedge reset)
        if (reset)
        begin
            waitCnt   <= 8'h0;
            served    <= 1'b0;
            metAck    <= 1'b0;
            metRdData <= 32'h5a5a5a5a;
        end
        else
        begin
            metAck    <= 1'b0;
            metRdData <= ~metRdData;
            if (!metReq)
            begin
                waitCnt <= 8'h0;
                served  <= 1'b0;
            end
            else if (!served && ackDelay != 8'hff && waitCnt == ackDelay)
            begin
                metAck    <= 1'b1;
                served    <= 1'b1;
                metRdData <= regs[metAddr];
                if (metWrite)
                    regs[metAddr] <= metWrData;
            end
            else if (!served)
                waitCnt <= waitCnt + 8'h1;
        end
endmodule

// ==== sim/metering_register_access_bridge_tb.sv ====
`timescale 1ns/1ps
module metering_register_access_bridge_tb;
    import mrab_pkg::*;
    // ----------
    // stimulus and observed signals
    // ----------
    typedef struct { logic [17:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r; } mrab_row_t;
    localparam logic [17:0] UNL_A = {IDX_UNLOCK, 2'b00};
    localparam logic [17:0] DONE_A = {IDX_DONE, 2'b00};
    localparam logic [17:0] SEL_A = {IDX_CLK_SEL, 2'b00};
    logic clk_sys, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, metWrData, metRdData, d, w;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        metReq, metWrite, metAck;
    logic [7:0]  metAddr, ackDelay;
    int          failCount, numChecks;
    // byte rows: address, written word, word read back, response
    mrab_row_t rows [7] = '{'{18'h0a200, 32'h1a5, 32'ha5, RESP_OKAY},
        '{18'h0a204, 32'h66, 32'h66, RESP_OKAY}, '{18'h0a208, 32'h77, 32'h77, RESP_OKAY},
        '{18'h0a20c, 32'h88, 32'h88, RESP_OKAY}, '{18'h0a214, 32'h1, 32'h0, RESP_OKAY},
        '{18'h0a220, 32'h6, 32'h2, RESP_OKAY}, '{18'h0a218, 32'h5, 32'h0, RESP_SLVERR}};
    mrab_bridge dut_u (.*);
    mrab_engine_model model_u (.*);
    // ----------
    // bus tasks and comparison
    // ----------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // both halves offered together, each dropped once taken
    task automatic axiW(input logic [17:0] a, input logic [31:0] v, output logic [1:0] q);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiR(input logic [17:0] a, output logic [31:0] v, output logic [1:0] q);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        q = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [17:0] win(input logic [7:0] i);
        return {IDX_METER_WIN, i, 2'b00};
    endfunction
    task automatic unlock();
        axiW(UNL_A, 32'(UNLOCK_KEY), r);
        axiW(UNL_A, 32'(UNLOCK_CLOSE), r);
    endtask
    task automatic putWord(input logic [31:0] v);
        for (int b = 0; b < 4; b++)
            axiW(18'h0a200 + 18'(4 * b), 32'(v[8*b +: 8]), r);
    endtask
    task automatic getWord(output logic [31:0] v);
        logic [31:0] t;
        for (int b = 0; b < 4; b++)
        begin
            axiR(18'h0a200 + 18'(4 * b), t, r);
            v[8*b +: 8] = t[7:0];
        end
    endtask
    // poll the done flag, bounded; slow ticks need many polls
    task automatic waitIdle();
        for (int k = 0; k < 1000; k++)
        begin
            axiR(DONE_A, d, r);
            if (d === 32'(DONE_IDLE))
                break;
        end
        chk("done idle", d, 32'(DONE_IDLE));
    endtask
    task automatic finishTest();
        if (failCount == 0 && numChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------
    // clock, watchdog and main sequence
    // ----------
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // run needs about four thousand cycles; ten times that is a hang
    initial
    begin
        #160000;
        failCount++;
        finishTest();
    end
    initial
    begin
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        ackDelay = 8'h0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            axiR(rows[i].a, d, r);
            chk("reset value", d, 32'h0);
            axiW(rows[i].a, rows[i].w, r);
            chk("write resp", 32'(r), 32'(rows[i].r));
            axiR(rows[i].a, d, r);
            chk("read back", d, rows[i].e);
            chk("read resp", 32'(r), 32'(rows[i].r));
        end
        // every rate, write a register then read it back through the window
        for (int s = 0; s < 4; s++)
        begin
            w = 32'ha1b2c3d4 + 32'(s);
            axiW(SEL_A, 32'(s), r);
            ackDelay <= 8'(10 + 5 * s);
            putWord(w);
            unlock();
            axiW(win(8'h20 + 8'(s)), 32'h0, r);
            axiR(DONE_A, d, r);
            chk("done busy", d, 32'(DONE_BUSY));
            waitIdle();
            chk("engine reg", model_u.regs[8'h20 + 8'(s)], w);
            putWord(32'h0);
            unlock();
            axiR(win(8'h20 + 8'(s)), d, r);
            chk("window read", d, 32'h0);
            waitIdle();
            getWord(d);
            chk("read word", d, w);
        end
        // broken unlock relocks; the address access is ignored
        axiW(UNL_A, 32'(UNLOCK_KEY), r);
        axiW(UNL_A, 32'h55, r);
        putWord(32'h5555aaaa);
        axiW(win(8'h21), 32'h0, r);
        axiR(DONE_A, d, r);
        chk("locked done", d, 32'(DONE_IDLE));
        chk("locked reg", model_u.regs[8'h21], 32'ha1b2c3d5);
        // silent engine: timeout, busy access ignored, data bytes kept
        axiW(SEL_A, 32'h3, r);
        ackDelay <= 8'hff;
        unlock();
        putWord(32'hcafe0001);
        axiW(win(8'h30), 32'h0, r);
        axiW(win(8'h20), 32'h0, r);
        waitIdle();
        getWord(d);
        chk("timeout word", d, 32'hcafe0001);
        chk("busy reg", model_u.regs[8'h20], 32'ha1b2c3d4);
        // reset in mid-run clears the buffers
        axiW(18'h0a200, 32'h3c, r);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        axiR(18'h0a200, d, r);
        chk("reset clears", d, 32'h0);
        finishTest();
    end
endmodule
